// File: hdl/lpmb_defines.vh
// constants for the lpc two-way mailbox block
`ifndef LPMB_DEFINES_VH
`define LPMB_DEFINES_VH
`define LPMB_CYC_IO_RD      4'h0
`define LPMB_CYC_IO_WR      4'h2
`define LPMB_ST_START       4'h0
`define LPMB_TAR_CYCLES     2'h2
`define LPMB_SYNC_READY     4'h0
`define LPMB_STR_SEL_OFS    4'h8
`define LPMB_SEL_INTERFACE_STATUS_3_BIT   7
`define LPMB_SEL_RESET      8'h03
`define LPMB_TWR_RESET      8'h00
`define LPMB_BASE_H_RESET   8'h00
`define LPMB_BASE_L_RESET   8'h00
`define LPMB_SLV_TWR_OFS    5'h00
`define LPMB_SLV_STR_OFS    5'h10
`define LPMB_SLV_SEL_OFS    5'h14
`define LPMB_SLV_BASEH_OFS  5'h15
`define LPMB_SLV_BASEL_OFS  5'h16
`define LPMB_SLV_RIGHTS_OFS 5'h17
`define LPMB_FLAG_HOST_OWN  0
`define LPMB_FLAG_SLV_OWN   1
`endif

// File: hdl/lpmb_sync.v
// two flip-flop synchroniser bank
`timescale 1ns/1ps
`default_nettype none
module lpmb_sync #(
	parameter W = 6
) (
	input  wire         sys_clk_i,
	input  wire         rst_i,
	input  wire [W-1:0] async_i,
	output reg  [W-1:0] sync_o
);
	reg [W-1:0] meta_r;
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			meta_r <= {W{1'b0}};
			sync_o <= {W{1'b0}};
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule
`default_nettype wire

// File: hdl/lpmb_mailbox.v
// lpc two-way register mailbox, device side
// Overview of operation
// - sixteen byte mailboxes are read and written by both host and slave.
// - mailbox 0 has a host-written half and a slave-written half at one address.
// - both parties start writes to mailbox 0 and learn acceptance from status flags.
// - with host rights the host half is selected and slave writes are dropped.
// - with slave rights the slave half is selected and host writes are dropped.
// - the host register is chosen by io address against the channel 3 base.
// - io writes store the byte in the chosen mailbox and io reads return it.
// - all mailboxes including both halves of mailbox 0 reset to zero.
// - four status bytes report interface state and are readable by host io reads.
// - status 3 upper nibble is software bits only when select bit 7 is 1 and enable is 0.
// - each frame select bit sets the serial irq idle and asserted drive.
// - select resets to 0x03 and is reachable from the slave only.
`timescale 1ns/1ps
`default_nettype none
`include "lpmb_defines.vh"
module lpmb_mailbox (
	input  wire       sys_clk_i,
	input  wire       rst_i,
	input  wire       lclk_i,
	input  wire       lframe_n_i,
	input  wire [3:0] lad_i,
	output reg  [3:0] lad_o,
	output reg        lad_oe_o,
	input  wire [6:0] irq_req_i,
	output reg        serirq_o,
	output reg        serirq_oe_o,
	input  wire [6:0] irq_slot_i,
	input  wire       slv_wr_i,
	input  wire       slv_rd_i,
	input  wire [4:0] slv_addr_i,
	input  wire [7:0] slv_wdata_i,
	output reg  [7:0] slv_rdata_o,
	output reg        host_wr_o
);
	localparam S_IDLE = 6'b000001, S_CYC = 6'b000010, S_ADDR = 6'b000100;
	localparam S_DATA = 6'b001000, S_TAR = 6'b010000, S_RESP = 6'b100000;
	wire [5:0] sy;
	lpmb_sync #(.W(6)) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i    (rst_i),
		.async_i  ({lclk_i, lframe_n_i, lad_i}),
		.sync_o   (sy)
	);
	reg        lclk_d_r;
	reg [5:0]  st_r;
	reg [3:0]  cnt_r;
	reg        is_wr_r;
	reg [15:0] addr_r;
	reg [7:0]  data_r;
	reg [7:0]  twr_r [1:15];
	reg [7:0]  h2s0_r;
	reg [7:0]  s2h0_r;
	reg        host_own_r;
	reg        slv_own_r;
	reg [7:0]  sel_r;
	reg [7:0]  base_h_r;
	reg [7:0]  base_l_r;
	reg [3:0]  interface_status_3_sw_r;
	reg [7:0]  rd_byte_r;
	integer    i;
	wire       rise = sy[5] & ~lclk_d_r;
	wire [3:0] ld = sy[3:0];
	wire       fr_n = sy[4];
	wire       twr_en = base_l_r[0];
	// base match ignoring low 5 bits
	function hit;
		input [15:0] a;
		input [15:0] b;
		begin
			hit = (a[15:5] == b[15:5]);
		end
	endfunction
	wire [15:0] base = {base_h_r, base_l_r[7:5], 5'h00};
	wire        h_hit = hit(addr_r, base);
	wire        h_str = addr_r[4];
	wire [3:0]  h_idx = addr_r[3:0];
	// edge gated: a write held a whole link clock could win rights late
	wire        h_wr_s = rise && fr_n && (st_r == S_TAR) && (cnt_r == 4'h0)
	                     && is_wr_r && h_hit;
	wire        h_wr0 = h_wr_s && !h_str && (h_idx == 4'h0);
	wire        s_wr0 = slv_wr_i && (slv_addr_i == `LPMB_SLV_TWR_OFS);
	// status bytes, 3 upper nibble per select
	wire [7:0] str1 = {6'h00, slv_own_r, host_own_r};
	wire [7:0] str2 = {4'h0, host_wr_o, is_wr_r, 2'h0};
	wire [3:0] interface_status_3_hi = (sel_r[`LPMB_SEL_INTERFACE_STATUS_3_BIT] && !twr_en) ? interface_status_3_sw_r
	                     : {host_own_r, slv_own_r, twr_en, 1'b0};
	wire [7:0] interface_status_3 = {interface_status_3_hi, 4'h0};
	wire [7:0] str4 = 8'h00;
	wire [7:0] host_view0 = host_own_r ? h2s0_r : s2h0_r;
	wire [7:0] slv_view0  = slv_own_r  ? s2h0_r : h2s0_r;
	always @* begin
		rd_byte_r = 8'h00;
		if (!h_str) begin
			rd_byte_r = (h_idx == 4'h0) ? host_view0 : twr_r[h_idx];
		end else if (h_idx[3:2] == 2'h2) begin
			case (h_idx[1:0])
				2'h0: rd_byte_r = str1;
				2'h1: rd_byte_r = str2;
				2'h2: rd_byte_r = interface_status_3;
				default: rd_byte_r = str4;
			endcase
		end
	end
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			lclk_d_r <= 1'b0;
			st_r     <= S_IDLE;
			cnt_r    <= 4'h0;
			is_wr_r  <= 1'b0;
			addr_r   <= 16'h0000;
			data_r   <= 8'h00;
			lad_o    <= 4'h0;
			lad_oe_o <= 1'b0;
			host_wr_o <= 1'b0;
		end else begin
			lclk_d_r  <= sy[5];
			host_wr_o <= 1'b0;
			if (rise) begin
				if (!fr_n) begin
					st_r     <= (ld == `LPMB_ST_START) ? S_CYC : S_IDLE;
					lad_oe_o <= 1'b0;
				end else begin
					case (st_r)
						S_CYC: begin
							is_wr_r <= (ld == `LPMB_CYC_IO_WR);
							st_r <= (ld == `LPMB_CYC_IO_WR || ld == `LPMB_CYC_IO_RD)
							        ? S_ADDR : S_IDLE;
							cnt_r <= 4'h0;
						end
						S_ADDR: begin
							addr_r <= {addr_r[11:0], ld};
							cnt_r  <= cnt_r + 4'h1;
							if (cnt_r == 4'h3) begin
								cnt_r <= 4'h0;
								st_r  <= is_wr_r ? S_DATA : S_TAR;
							end
						end
						S_DATA: begin
							// low nibble first on the wire
							data_r <= {ld, data_r[7:4]};
							cnt_r  <= cnt_r + 4'h1;
							if (cnt_r == 4'h1) begin
								cnt_r <= 4'h0;
								st_r  <= S_TAR;
							end
						end
						S_TAR: begin
							cnt_r <= cnt_r + 4'h1;
							if (cnt_r == 4'h0 && is_wr_r && h_hit)
								host_wr_o <= 1'b1;
							if (cnt_r == {2'h0, `LPMB_TAR_CYCLES} - 4'h1) begin
								cnt_r <= 4'h0;
								st_r  <= h_hit ? S_RESP : S_IDLE;
								if (!is_wr_r)
									data_r <= rd_byte_r;
							end
						end
						S_RESP: begin
							lad_oe_o <= 1'b1;
							cnt_r    <= cnt_r + 4'h1;
							case (cnt_r)
								4'h0: lad_o <= `LPMB_SYNC_READY;
								4'h1: lad_o <= is_wr_r ? 4'hf : data_r[3:0];
								4'h2: lad_o <= is_wr_r ? 4'hf : data_r[7:4];
								default: lad_o <= 4'hf;
							endcase
							if ((is_wr_r && cnt_r == 4'h2) || cnt_r == 4'h4) begin
								lad_oe_o <= 1'b0;
								st_r     <= S_IDLE;
							end
						end
						default: st_r <= S_IDLE;
					endcase
				end
			end
		end
	end
	// mailbox storage and rights arbitration
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			for (i = 1; i < 16; i = i + 1)
				twr_r[i] <= `LPMB_TWR_RESET;
			h2s0_r     <= `LPMB_TWR_RESET;
			s2h0_r     <= `LPMB_TWR_RESET;
			host_own_r <= 1'b0;
			slv_own_r  <= 1'b0;
			sel_r      <= `LPMB_SEL_RESET;
			base_h_r   <= `LPMB_BASE_H_RESET;
			base_l_r   <= `LPMB_BASE_L_RESET;
			interface_status_3_sw_r  <= 4'h0;
		end else begin
			// host wins tie, first writer owns
			if (h_wr0 && !slv_own_r) begin
				h2s0_r     <= data_r;
				host_own_r <= 1'b1;
			end else if (s_wr0 && !host_own_r) begin
				s2h0_r    <= slv_wdata_i;
				slv_own_r <= 1'b1;
			end
			// slave clears rights flags to reopen
			if (slv_wr_i && slv_addr_i == `LPMB_SLV_RIGHTS_OFS) begin
				if (slv_wdata_i[`LPMB_FLAG_HOST_OWN] && !h_wr0)
					host_own_r <= 1'b0;
				if (slv_wdata_i[`LPMB_FLAG_SLV_OWN] && !s_wr0)
					slv_own_r <= 1'b0;
			end
			if (h_wr_s && !h_str && h_idx != 4'h0)
				twr_r[h_idx] <= data_r;
			if (slv_wr_i) begin
				if (slv_addr_i[4] == 1'b0 && slv_addr_i[3:0] != 4'h0)
					twr_r[slv_addr_i[3:0]] <= slv_wdata_i;
				else if (slv_addr_i == `LPMB_SLV_SEL_OFS)
					sel_r <= slv_wdata_i;
				else if (slv_addr_i == `LPMB_SLV_BASEH_OFS)
					base_h_r <= slv_wdata_i;
				else if (slv_addr_i == `LPMB_SLV_BASEL_OFS)
					base_l_r <= slv_wdata_i;
				else if (slv_addr_i == `LPMB_SLV_STR_OFS + 5'h02)
					interface_status_3_sw_r <= slv_wdata_i[7:4];
			end
		end
	end
	// slave read port, registered
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			slv_rdata_o <= 8'h00;
		end else if (slv_rd_i) begin
			if (slv_addr_i[4] == 1'b0)
				slv_rdata_o <= (slv_addr_i[3:0] == 4'h0) ? slv_view0
				               : twr_r[slv_addr_i[3:0]];
			else if (slv_addr_i == `LPMB_SLV_STR_OFS)
				slv_rdata_o <= str1;
			else if (slv_addr_i == `LPMB_SLV_STR_OFS + 5'h01)
				slv_rdata_o <= str2;
			else if (slv_addr_i == `LPMB_SLV_STR_OFS + 5'h02)
				slv_rdata_o <= interface_status_3;
			else if (slv_addr_i == `LPMB_SLV_SEL_OFS)
				slv_rdata_o <= sel_r;
			else if (slv_addr_i == `LPMB_SLV_BASEH_OFS)
				slv_rdata_o <= base_h_r;
			else if (slv_addr_i == `LPMB_SLV_BASEL_OFS)
				slv_rdata_o <= base_l_r;
			else if (slv_addr_i == `LPMB_SLV_RIGHTS_OFS)
				slv_rdata_o <= str1;
			else
				slv_rdata_o <= 8'h00;
		end
	end
	// serial irq drive per polarity; slot framing is left to the caller
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			serirq_o    <= 1'b0;
			serirq_oe_o <= 1'b0;
		end else begin
			serirq_o    <= 1'b0;
			serirq_oe_o <= |(irq_slot_i & (irq_req_i ^ sel_r[6:0]));
		end
	end
endmodule
`default_nettype wire

// File: tb/lpmb_mailbox_props.sv
// port assertions for the lpc mailbox
`timescale 1ns/1ps
`default_nettype none
module lpmb_mailbox_props (
	input wire       sys_clk_i,
	input wire       rst_i,
	input wire       lframe_n_i,
	input wire [3:0] lad_o,
	input wire       lad_oe_o,
	input wire       serirq_o,
	input wire       serirq_oe_o,
	input wire [6:0] irq_slot_i,
	input wire       slv_rd_i,
	input wire [7:0] slv_rdata_o,
	input wire       host_wr_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// one link clock is eight system clocks, jitter allowed
	sequence sync_s;
		(lad_oe_o && lad_o == 4'h0) [*6];
	endsequence
	sequence tail_s;
		$past(lad_o) == 4'hf;
	endsequence
	sync_first_a: assert property ($rose(lad_oe_o) |-> sync_s)
		else $error("drive not opened by sync");
	release_tail_a: assert property ($fell(lad_oe_o) |-> tail_s)
		else $error("release without turnaround");
	frame_quiet_a: assert property (!lframe_n_i |-> !lad_oe_o)
		else $error("drive during frame start");
	wr_pulse_a: assert property (host_wr_o |=> !host_wr_o)
		else $error("host write pulse too long");
	rdata_hold_a: assert property (!$past(slv_rd_i) |-> $stable(slv_rdata_o))
		else $error("read data moved");
	serirq_low_a: assert property (serirq_o == 1'b0)
		else $error("serirq driven high");
	slot_idle_a: assert property (irq_slot_i == 7'h00 |=> !serirq_oe_o)
		else $error("serirq driven off slot");
	reset_clear_a: assert property (disable iff (1'b0) rst_i |=> !lad_oe_o && !slv_rdata_o)
		else $error("outputs not cleared");
endmodule
bind lpmb_mailbox lpmb_mailbox_props u_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
	.lframe_n_i(lframe_n_i), .lad_o(lad_o), .lad_oe_o(lad_oe_o), .serirq_o(serirq_o),
	.serirq_oe_o(serirq_oe_o), .irq_slot_i(irq_slot_i), .slv_rd_i(slv_rd_i),
	.slv_rdata_o(slv_rdata_o), .host_wr_o(host_wr_o));
`default_nettype wire

// File: tb/lpmb_host.sv
// lpc host model issuing io cycles
`timescale 1ns/1ps
`default_nettype none
module lpmb_host (
	input  wire        sys_clk_i,
	input  wire  [3:0] bus_i,
	output logic       lclk_o,
	output logic       lframe_n_o,
	output logic [3:0] lad_o,
	output logic       oe_o,
	output logic       done_o,
	output logic [7:0] data_o
);
	logic [3:0] smp;
	initial {lclk_o, lframe_n_o, lad_o, oe_o, done_o, data_o} = 16'h7c00;
	// clock only inside frames, sample before rise
	task automatic nib(input logic [3:0] v, input logic drv);
		lad_o = v;
		oe_o = drv;
		#200 smp = bus_i;
		lclk_o = 1'b1;
		#200 lclk_o = 1'b0;
	endtask
	task automatic cyc(input logic wr, input logic [15:0] a, input logic [7:0] d);
		#17 lframe_n_o = 1'b0;
		nib(4'h0, 1'b1);
		lframe_n_o = 1'b1;
		nib({2'b00, wr, 1'b0}, 1'b1);
		for (int i = 3; i >= 0; i--) nib(a[i*4+:4], 1'b1);
		if (wr) begin
			nib(d[3:0], 1'b1);
			nib(d[7:4], 1'b1);
		end
		nib(4'hf, 1'b1);
		nib(4'hf, 1'b0);
		// device answers one link clock after turnaround; no hit leaves pulled-up ones
		nib(4'hf, 1'b0);
		if (!wr) begin
			// sync nibble stands before this rise
			nib(4'hf, 1'b0);
			nib(4'hf, 1'b0);
			data_o[3:0] = smp;
			nib(4'hf, 1'b0);
			data_o[7:4] = smp;
			done_o = 1'b1;
			@(posedge sys_clk_i) #1 done_o = 1'b0;
		end
		repeat (3) nib(4'hf, 1'b0);
	endtask
endmodule
`default_nettype wire

// File: tb/lpmb_mailbox_tb.sv
// self-checking bench for the lpc mailbox
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; exp_v = (e); if ((a) !== exp_v) begin err_count++; \
	$display("mismatch %0t %h/%h", $time, a, exp_v); end end
module lpmb_mailbox_tb;
	logic       sys_clk_i, rst_i, lclk, lfr_n, h_oe, hdone, slv_wr, slv_rd, irq_chk, rd_d;
	logic       lad_oe, serirq_oe, hwr;
	logic [31:0] exp_v;
	logic [3:0] h_lad, lad_o;
	logic [6:0] irq_req, irq_slot;
	logic [4:0] slv_addr;
	logic [7:0] slv_wdata, slv_rdata, hdata, d, sel;
	logic [7:0] exp_q[$];
	int         err_count, tests_run, i, k, rnd, wr_cnt;
	wire  [3:0] bus = lad_oe ? lad_o : (h_oe ? h_lad : 4'hf);
	lpmb_mailbox dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .lclk_i(lclk), .lframe_n_i(lfr_n),
		.lad_i(bus), .lad_o(lad_o), .lad_oe_o(lad_oe), .irq_req_i(irq_req), .serirq_o(),
		.serirq_oe_o(serirq_oe), .irq_slot_i(irq_slot), .slv_wr_i(slv_wr), .slv_rd_i(slv_rd),
		.slv_addr_i(slv_addr), .slv_wdata_i(slv_wdata), .slv_rdata_o(slv_rdata), .host_wr_o(hwr));
	lpmb_host host (.sys_clk_i(sys_clk_i), .bus_i(bus), .lclk_o(lclk), .lframe_n_o(lfr_n),
		.lad_o(h_lad), .oe_o(h_oe), .done_o(hdone), .data_o(hdata));
	task automatic end_of_test;
		if (err_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic sw(input logic [4:0] a, input logic [7:0] v);
		@(posedge sys_clk_i);
		slv_wr <= 1'b1;
		slv_addr <= a;
		slv_wdata <= v;
		@(posedge sys_clk_i);
		slv_wr <= 1'b0;
	endtask
	task automatic sr(input logic [4:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge sys_clk_i);
		slv_rd <= 1'b1;
		slv_addr <= a;
		@(posedge sys_clk_i);
		slv_rd <= 1'b0;
	endtask
	task automatic hr(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.cyc(1'b0, a, 8'h00);
	endtask
	always @(posedge sys_clk_i) begin
		rd_d <= slv_rd;
		if (hwr)
			wr_cnt <= wr_cnt + 1;
		if (irq_chk)
			`CHK({7'h00, serirq_oe}, exp_q.pop_front())
		else if (hdone)
			`CHK(hdata, exp_q.pop_front())
		else if (rd_d)
			`CHK(slv_rdata, exp_q.pop_front())
	end
	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		#2ms;
		err_count++;
		$display("mismatch %0t timeout", $time);
		end_of_test;
	end
	initial begin
		rst_i <= 1'b1;
		{slv_wr, slv_rd, irq_chk, slv_addr, slv_wdata, irq_req, irq_slot} <= 30'h0;
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		rnd = $urandom(54);
		for (i = 0; i < 16; i++) sr(i[4:0], 8'h00);
		sr(5'h14, 8'h03);
		// base 0x0ca0, two-way enable set
		sw(5'h15, 8'h0c);
		sw(5'h16, 8'ha1);
		for (i = 1; i < 16; i++) begin
			d = 8'($urandom);
			sw(i[4:0], d);
			hr(16'h0ca0 | i[15:0], d);
			d = 8'($urandom);
			host.cyc(1'b1, 16'h0ca0 | i[15:0], d);
			sr(i[4:0], d);
		end
		hr(16'h0cc0, 8'hff);
		hr(16'h0cbb, 8'h00);
		sw(5'h17, 8'h03);
		host.cyc(1'b1, 16'h0ca0, 8'h5a);
		sw(5'h00, 8'ha5);
		sr(5'h00, 8'h5a);
		sr(5'h17, 8'h01);
		hr(16'h0ca0, 8'h5a);
		sw(5'h17, 8'h01);
		sw(5'h00, 8'h3c);
		host.cyc(1'b1, 16'h0ca0, 8'hc3);
		sr(5'h00, 8'h3c);
		hr(16'h0ca0, 8'h3c);
		hr(16'h0cb8, 8'h02);
		// software status bits need select set and two-way enable clear
		sw(5'h16, 8'ha0);
		sw(5'h14, 8'h80);
		sw(5'h12, 8'h90);
		sr(5'h12, 8'h90);
		sw(5'h16, 8'ha1);
		sw(5'h14, 8'h03);
		sel = 8'h03;
		for (k = 0; k < 28; k++) begin
			if (k == 14) begin
				sel = 8'h7c;
				sw(5'h14, sel);
			end
			d = 8'($urandom);
			d[k % 7] = (k / 7) % 2;
			exp_q.push_back({7'h00, d[k % 7] ^ sel[k % 7]});
			@(posedge sys_clk_i);
			irq_slot <= 7'h01 << (k % 7);
			irq_req <= d[6:0];
			@(posedge sys_clk_i);
			irq_chk <= 1'b1;
			@(posedge sys_clk_i);
			irq_chk <= 1'b0;
		end
		repeat (3) @(posedge sys_clk_i);
		// seventeen host writes hit the base
		`CHK(wr_cnt, 17)
		end_of_test;
	end
endmodule
`default_nettype wire
